/* File: hw/fmacr_consts.vh */
// Constants for the fault mask and monitor converter setup register group.
// Assumes inclusion by bare name from the design files of this block.
`ifndef FMACR_CONSTS_VH
`define FMACR_CONSTS_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FMACR_OFS_MASK_A 8'h2C
`define FMACR_OFS_MASK_B 8'h2D
`define FMACR_OFS_CONV 8'h2E
`define FMACR_OFS_CHAN 8'h2F
// ----------------------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------------------
`define FMACR_RST_MASK_A 8'h00
`define FMACR_RST_MASK_B 8'h00
`define FMACR_RST_CONV 8'h30
`define FMACR_RST_CHAN 8'h00
`define FMACR_WMASK_MASK_A 8'hFF
`define FMACR_WMASK_MASK_B 8'hFC
`define FMACR_WMASK_CONV 8'hFF
`define FMACR_WMASK_CHAN 8'hFE
// ----------------------------------------------------------------------------
// Converter setup fields
// ----------------------------------------------------------------------------
`define FMACR_CONV_EN 7
`define FMACR_CONV_ONESHOT 6
`define FMACR_CONV_SPEED_HI 5
`define FMACR_CONV_SPEED_LO 4
`define FMACR_CONV_MEAN 3
`define FMACR_CONV_SEED 2
`define FMACR_RES_BASE 4'hF
`define FMACR_RES_RESET 4'hC
`define FMACR_CONV_EN_CLR 8'h7F
// ----------------------------------------------------------------------------
// Event vector layout: bits 7..0 mask A events, 15..8 mask B, 16 conversion done
// ----------------------------------------------------------------------------
`define FMACR_EVT_W 17
`define FMACR_EVT_DONE 16
`endif

/* File: hw/fmacr_reg8.v */
// One 8-bit software register with reset value and per-bit write mask.
// Assumes a synchronous write strobe in the mclk_i domain.
`timescale 1ns/100ps
module fmacr_reg8 #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WMASK = 8'hFF
) (
  input wire mclk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] q_o
);
  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // Read-only bits never take write data, so they keep reading as their reset value.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      q_o <= RESET_VAL;
    end else if (wr_i) begin
      q_o <= (wdata_i & WMASK) | (RESET_VAL & ~WMASK);
    end
  end
endmodule // fmacr_reg8

/* File: hw/fmacr_irq_gate.v */
// Masked event to interrupt pulse generator.
// Assumes events arrive as one-cycle pulses synchronous to mclk_i.
`timescale 1ns/100ps
module fmacr_irq_gate #(
  parameter W = 17
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [W-1:0] evt_i,
  input wire [W-1:0] block_i,
  output reg irq_pulse_o
);
  // ---------------------------------------------------------------------------
  // Gating
  // ---------------------------------------------------------------------------
  // Any unblocked event yields a single-cycle pulse; blocked events still reach
  // the status logic upstream, only the signalling is dropped here.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_pulse_o <= 1'b0;
    end else begin
      irq_pulse_o <= |(evt_i & ~block_i);
    end
  end
endmodule // fmacr_irq_gate

/* File: hw/fmacr_top.v */
// Fault interrupt mask and monitor converter setup registers.
// Assumes a byte-wide register port from the serial management bus front end,
// with one-cycle write and read strobes synchronous to mclk_i.
`timescale 1ns/100ps
`include "fmacr_consts.vh"
module fmacr_top (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire reg_reset_i,
  input wire watchdog_expire_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] fault_evt_a_i,
  input wire [7:0] fault_evt_b_i,
  input wire conv_done_i,
  input wire done_irq_block_i,
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  output reg irq_o,
  output reg [7:0] fault_seen_a_o,
  output reg [7:0] fault_seen_b_o,
  output reg conv_run_o,
  output reg conv_oneshot_o,
  output reg [3:0] conv_res_bits_o,
  output reg running_mean_select_o,
  output reg mean_seed_select_o,
  output reg [6:0] chan_off_o
);
  // ---------------------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------------------
  wire regs_rst;
  wire conv_wr;
  wire [7:0] conv_wdata;
  wire wr_mask_a;
  wire wr_mask_b;
  wire wr_conv;
  wire wr_chan;
  wire [7:0] mask_a;
  wire [7:0] mask_b;
  wire [7:0] conv_setup;
  wire [7:0] chan_off;
  wire irq_pulse;
  wire [`FMACR_EVT_W-1:0] evt_vec;
  wire [`FMACR_EVT_W-1:0] block_vec;
  reg [7:0] next_rdata;

  // Address compare used by both write decode and read mux.
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign regs_rst = sys_rst_i | reg_reset_i;
  // Watchdog expiry clears only the converter enable; the other setup fields keep
  // what software wrote. Expiry beats a write in the same cycle so the stop sticks.
  assign conv_wr = wr_conv | watchdog_expire_i;
  assign conv_wdata = watchdog_expire_i ? (conv_setup & `FMACR_CONV_EN_CLR) : wdata_i;
  assign wr_mask_a = wr_i & hit(addr_i, `FMACR_OFS_MASK_A);
  assign wr_mask_b = wr_i & hit(addr_i, `FMACR_OFS_MASK_B);
  assign wr_conv = wr_i & hit(addr_i, `FMACR_OFS_CONV);
  assign wr_chan = wr_i & hit(addr_i, `FMACR_OFS_CHAN);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Mask A: every bit writable, each blocks one fault interrupt.
  fmacr_reg8 #(.RESET_VAL(`FMACR_RST_MASK_A), .WMASK(`FMACR_WMASK_MASK_A)) u_mask_a (
    .mclk_i(mclk_i), .rst_i(regs_rst), .wr_i(wr_mask_a), .wdata_i(wdata_i), .q_o(mask_a)
  );

  // Mask B: bits 1-0 are read-only zero; bit 3 is a writable spare.
  fmacr_reg8 #(.RESET_VAL(`FMACR_RST_MASK_B), .WMASK(`FMACR_WMASK_MASK_B)) u_mask_b (
    .mclk_i(mclk_i), .rst_i(regs_rst), .wr_i(wr_mask_b), .wdata_i(wdata_i), .q_o(mask_b)
  );

  // Converter setup: returns to 0x30 on reset; watchdog rewrites it with enable low.
  fmacr_reg8 #(.RESET_VAL(`FMACR_RST_CONV), .WMASK(`FMACR_WMASK_CONV)) u_conv (
    .mclk_i(mclk_i), .rst_i(regs_rst), .wr_i(conv_wr), .wdata_i(conv_wdata), .q_o(conv_setup)
  );

  // Channel-off register: bit 0 read-only zero.
  fmacr_reg8 #(.RESET_VAL(`FMACR_RST_CHAN), .WMASK(`FMACR_WMASK_CHAN)) u_chan (
    .mclk_i(mclk_i), .rst_i(regs_rst), .wr_i(wr_chan), .wdata_i(wdata_i), .q_o(chan_off)
  );

  // ---------------------------------------------------------------------------
  // Interrupt gating
  // ---------------------------------------------------------------------------
  // Done event only counts in single pass mode.
  assign evt_vec = {conv_done_i & conv_setup[`FMACR_CONV_ONESHOT], fault_evt_b_i,
                    fault_evt_a_i};
  assign block_vec = {done_irq_block_i, mask_b, mask_a};

  fmacr_irq_gate #(.W(`FMACR_EVT_W)) u_gate (
    .mclk_i(mclk_i), .sys_rst_i(regs_rst), .evt_i(evt_vec), .block_i(block_vec),
    .irq_pulse_o(irq_pulse)
  );

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  // Unmapped offsets read as zero.
  always @* begin
    next_rdata = 8'h00;
    if (hit(addr_i, `FMACR_OFS_MASK_A)) begin
      next_rdata = mask_a;
    end else if (hit(addr_i, `FMACR_OFS_MASK_B)) begin
      next_rdata = mask_b;
    end else if (hit(addr_i, `FMACR_OFS_CONV)) begin
      next_rdata = conv_setup;
    end else if (hit(addr_i, `FMACR_OFS_CHAN)) begin
      next_rdata = chan_off;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  // Outputs lag the registers by one cycle so each comes from a flip-flop.
  always @(posedge mclk_i) begin
    if (regs_rst) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
      irq_o <= 1'b0;
      fault_seen_a_o <= 8'h00;
      fault_seen_b_o <= 8'h00;
      conv_run_o <= 1'b0;
      conv_oneshot_o <= 1'b0;
      conv_res_bits_o <= `FMACR_RES_RESET;
      running_mean_select_o <= 1'b0;
      mean_seed_select_o <= 1'b0;
      chan_off_o <= 7'h00;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= next_rdata;
      end
      irq_o <= irq_pulse;
      // Raw events pass regardless of masks so protection still acts.
      fault_seen_a_o <= fault_evt_a_i;
      fault_seen_b_o <= fault_evt_b_i;
      conv_run_o <= conv_setup[`FMACR_CONV_EN] & ~watchdog_expire_i;
      conv_oneshot_o <= conv_setup[`FMACR_CONV_ONESHOT];
      conv_res_bits_o <= `FMACR_RES_BASE -
        {2'b00, conv_setup[`FMACR_CONV_SPEED_HI:`FMACR_CONV_SPEED_LO]};
      running_mean_select_o <= conv_setup[`FMACR_CONV_MEAN];
      mean_seed_select_o <= conv_setup[`FMACR_CONV_SEED];
      chan_off_o <= chan_off[7:1];
    end
  end
endmodule // fmacr_top

/* File: dv/fmacr_assertions.sv */
// Checker for the fault mask and converter setup register group.
// Sees only the ports of fmacr_top; bound to it at the foot of this file.
`timescale 1ns/100ps
module fmacr_assertions (
  input wire mclk_i, input wire sys_rst_i, input wire reg_reset_i,
  input wire watchdog_expire_i, input wire wr_i, input wire rd_i,
  input wire [7:0] addr_i, input wire [7:0] wdata_i,
  input wire [7:0] fault_evt_a_i, input wire [7:0] fault_evt_b_i,
  input wire conv_done_i, input wire done_irq_block_i, input wire rvalid_o,
  input wire irq_o, input wire [7:0] fault_seen_a_o, input wire [7:0] fault_seen_b_o,
  input wire conv_run_o, input wire conv_oneshot_o, input wire [3:0] conv_res_bits_o,
  input wire running_mean_select_o, input wire mean_seed_select_o
);
  reg [7:0] sh_a;
  reg [7:0] sh_b;
  reg [7:0] sh_c;
  reg [7:0] sh_d;
  wire rst = sys_rst_i | reg_reset_i;
  wire wr_run = wr_i && addr_i == 8'h2E && wdata_i[7];
  // Predicted gate input; the done event counts only in single-pass mode.
  wire hit = (|(fault_evt_a_i & ~sh_a)) || (|(fault_evt_b_i & ~sh_b)) ||
    (conv_done_i && !done_irq_block_i && sh_c[6]);
  // Shadows of the masks and setup, so the checker never trusts a read-back.
  always @(posedge mclk_i) begin
    if (rst) begin
      sh_a <= 8'h00;
      sh_b <= 8'h00;
      sh_c <= 8'h30;
    end else begin
      if (wr_i && addr_i == 8'h2C) sh_a <= wdata_i;
      if (wr_i && addr_i == 8'h2D) sh_b <= wdata_i & 8'hFC;
      if (watchdog_expire_i) sh_c <= sh_c & 8'h7F;
      else if (wr_i && addr_i == 8'h2E) sh_c <= wdata_i;
    end
    sh_d <= rst ? 8'h30 : sh_c;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (rd_i |=> rvalid_o)
    else $error("read not answered");
  chk_irq_fires: assert property (hit |-> ##2 irq_o)
    else $error("unmasked event gave no pulse");
  chk_irq_cause: assert property (irq_o |-> $past(hit, 2))
    else $error("pulse without unmasked event");
  chk_run_rise: assert property ($rose(conv_run_o) |-> $past(wr_run, 2))
    else $error("converter started without write");
  chk_wdog_stop: assert property (watchdog_expire_i && !wr_run |=> !conv_run_o [*2])
    else $error("watchdog left converter running");
  chk_conv_fields: assert property ({conv_oneshot_o, conv_res_bits_o, running_mean_select_o,
    mean_seed_select_o} == {sh_d[6], 4'hF - {2'b00, sh_d[5:4]}, sh_d[3:2]})
    else $error("converter setup outputs wrong");
  chk_seen_a: assert property (fault_seen_a_o == $past(fault_evt_a_i))
    else $error("group A event not recorded");
  chk_seen_b: assert property (fault_seen_b_o == $past(fault_evt_b_i))
    else $error("group B event not recorded");
endmodule // fmacr_assertions
bind fmacr_top fmacr_assertions fmacr_assertions_inst (.*);

/* File: dv/tb_fmacr_top.sv */
// Self-checking bench for fmacr_top through its byte-wide register port.
// Assumes the checker is bound in its own file; one 100 MHz clock.
`timescale 1ns/100ps
module tb_fmacr_top;
  reg mclk_i = 0, sys_rst_i = 1, reg_reset_i = 0, watchdog_expire_i = 0;
  reg wr_i = 0, rd_i = 0, conv_done_i = 0, done_irq_block_i = 0;
  reg [7:0] addr_i = 8'h00, wdata_i = 8'h00, fault_evt_a_i = 8'h00, fault_evt_b_i = 8'h00;
  wire [7:0] rdata_o, fault_seen_a_o, fault_seen_b_o;
  wire rvalid_o, irq_o, conv_run_o, conv_oneshot_o, running_mean_select_o, mean_seed_select_o;
  wire [3:0] conv_res_bits_o;
  wire [6:0] chan_off_o;
  integer n_fail = 0, checked = 0, i;
  reg [15:0] m;
  fmacr_top fmacr_top_inst (.*);
  // Free-running clock.
  initial forever #5 mclk_i = ~mclk_i;
  task ck(input [15:0] g, input [15:0] e);
    checked = checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge mclk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge mclk_i) wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge mclk_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge mclk_i) rd_i <= 1'b0;
    #1 ck({rvalid_o, rdata_o}, {1'b1, e});
  endtask
  // One event cycle; the pulse must follow two cycles later and last one cycle.
  task ev(input [15:0] v, input dn, input e);
    @(posedge mclk_i) {fault_evt_b_i, fault_evt_a_i, conv_done_i} <= {v, dn};
    @(posedge mclk_i) {fault_evt_b_i, fault_evt_a_i, conv_done_i} <= 17'h0;
    #1 ck({fault_seen_b_o, fault_seen_a_o}, v);
    @(posedge mclk_i) #1 ck(irq_o, e);
    @(posedge mclk_i) #1 ck(irq_o, 1'b0);
  endtask
  task end_of_test;
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(8'h2C, 8'h00);
    rd(8'h2E, 8'h30);
    wr(8'h2B, 8'hFF);
    rd(8'h2B, 8'h00);
    wr(8'h2D, 8'hFF);
    rd(8'h2D, 8'hFC);
    wr(8'h2F, 8'hFF);
    rd(8'h2F, 8'hFE);
    ck(chan_off_o, 7'h7F);
    // Every speed code, with the mode bits toggled alongside.
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h2E, {i[1:0], i[1:0], i[1:0], 2'b00});
      @(posedge mclk_i) #1;
      ck({conv_run_o, conv_oneshot_o, conv_res_bits_o, running_mean_select_o,
        mean_seed_select_o}, {i[1:0], 4'hF - i[3:0], i[1:0]});
    end
    // Each mask bit alone passes and blocks its own event; mask B bits 0, 1 and 3 skipped.
    for (i = 0; i < 16; i = i + 1) if (i != 8 && i != 9 && i != 11) begin
      m = 16'h1 << i;
      wr(8'h2C, ~m[7:0]);
      wr(8'h2D, ~m[15:8]);
      ev(m, 1'b0, 1'b1);
      wr(8'h2C, m[7:0]);
      wr(8'h2D, m[15:8]);
      ev(m, 1'b0, 1'b0);
    end
    ev(16'h0, 1'b1, 1'b1);
    done_irq_block_i <= 1'b1;
    ev(16'h0, 1'b1, 1'b0);
    done_irq_block_i <= 1'b0;
    wr(8'h2E, 8'h8C);
    ev(16'h0, 1'b1, 1'b0);
    @(posedge mclk_i) #1 ck(conv_run_o, 1'b1);
    @(posedge mclk_i) watchdog_expire_i <= 1'b1;
    @(posedge mclk_i) watchdog_expire_i <= 1'b0;
    @(posedge mclk_i) #1 ck(conv_run_o, 1'b0);
    rd(8'h2E, 8'h0C);
    wr(8'h2E, 8'h4C);
    wr(8'h2C, 8'hFF);
    @(posedge mclk_i) reg_reset_i <= 1'b1;
    @(posedge mclk_i) reg_reset_i <= 1'b0;
    rd(8'h2C, 8'h00);
    rd(8'h2D, 8'h00);
    rd(8'h2E, 8'h30);
    rd(8'h2F, 8'h00);
    ck(conv_res_bits_o, 4'hC);
    ck(chan_off_o, 7'h00);
    end_of_test;
  end
  // Hang guard: the sequence needs well under a tenth of this span.
  initial begin
    #200000;
    n_fail = n_fail + 1;
    $display("Error %0t: timeout", $time);
    end_of_test;
  end
endmodule // tb_fmacr_top
